//--- hdl/qrst_core.sv
// Switching control core of a quasi-resonant flyback controller.
// Assumes comparator inputs are asynchronous levels and izc_code is
// produced by logic on the same clock.
// How it works
// - Valley counter stays within 0 to 7.
// - Each falling aux crossing below 100mV while off adds one.
// - Valley counter clears whenever the gate goes high.
// - Aux above overvoltage level while off for blanking time latches off.
// - At turn-off, aux below suppression level picks long suppression, else short.
// - Gate stays low for the whole chosen suppression time.
// - After suppression, gate turns on when valley count reaches load count.
// - Gate turns on after maximum off-time regardless of counters.
// - Scaled current above feedback resets the output flip-flop.
// - Current comparators ignored for leading edge blanking after turn-on.
// - Gate forced off once high longer than maximum on-time.
// - After blanking, current limit comparator turns gate off at once.
// - Short-winding comparator acts after spike blanking, then latches off.
// - Aux current above foldback start lowers the current limit by the excess.
// - Burst flop sets after feedback low and load 7 hold 24ms.
// - Load counter updates from feedback thresholds once per 48ms.
// - Load counter saturates in 1 to 7 and resets to 1.
`timescale 1ns/10ps
`default_nettype none
module qrst_core
    import qrst_pkg::*;
#(
    parameter int EVAL_CYCLES = qrst_pkg::EVAL_CYC,
    parameter int BURST_BLANK_CYCLES = qrst_pkg::BURST_BLANK_CYC
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Comparator levels, asynchronous
    input wire logic aux_valley_sense,
    input wire logic aux_below_suppress,
    input wire logic aux_above_overvolt,
    input wire logic scaled_current_trip,
    input wire logic current_limit_trip,
    input wire logic short_winding_trip,
    input wire logic fb_below_burst_entry,
    input wire logic fb_above_zl,
    input wire logic fb_above_zh,
    input wire logic fb_above_r1,
    // Aux pin current measurement
    input wire logic [7:0] izc_code,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Outputs
    output logic gate_drive_out,
    output logic [7:0] cs_limit,
    output logic latched_off,
    output logic burst_mode,
    output logic irq
);
    typedef struct packed {
        logic [NCMP-1:0] s1;
        logic [NCMP-1:0] s2;
        logic val_d;
        logic gate;
        logic [2:0] valley;
        logic [2:0] load;
        logic [TMR_W-1:0] tmr;
        logic long_supp;
        logic [7:0] ovp_cnt;
        logic [7:0] sw_cnt;
        logic latched;
        logic burst;
        logic [LONG_W-1:0] eval_cnt;
        logic [LONG_W-1:0] beb_cnt;
        logic zl_seen;
        logic zh_seen;
        logic r1_seen;
        logic [7:0] cs_limit;
        logic enable;
        logic [NEV-1:0] status;
        logic [NEV-1:0] mask;
        logic [31:0] rdata;
        logic irq;
    } qrst_state_type;

    qrst_state_type st_r;
    qrst_state_type st_nxt;

    localparam logic [TMR_W-1:0] T_SHORT = TMR_W'(SHORT_SUPP_CYC);
    localparam logic [TMR_W-1:0] T_LONG = TMR_W'(LONG_SUPP_CYC);
    localparam logic [TMR_W-1:0] LEADING_EDGE_BLANK_TIME = TMR_W'(LEB_CYC);
    localparam logic [TMR_W-1:0] T_MAXON = TMR_W'(MAX_ON_CYC);
    localparam logic [TMR_W-1:0] T_MAXOFF = TMR_W'(MAX_OFF_CYC);
    localparam logic [7:0] T_OVP = 8'(OVP_BLANK_CYC);
    localparam logic [7:0] T_SW = 8'(SW_BLANK_CYC);
    localparam logic [LONG_W-1:0] T_EVAL = LONG_W'(EVAL_CYCLES);
    localparam logic [LONG_W-1:0] BURST_ENTRY_BLANK_TIME = LONG_W'(BURST_BLANK_CYCLES);

    // Saturating step of an eight-bit blanking counter
    function automatic logic [7:0] inc8(input logic [7:0] v);
        inc8 = (v == 8'hff) ? v : v + 8'h1;
    endfunction : inc8

    // Saturating step of a long period counter
    function automatic logic [LONG_W-1:0] inc_l(input logic [LONG_W-1:0] v);
        inc_l = (&v) ? v : v + LONG_W'(1);
    endfunction : inc_l

    logic [NCMP-1:0] cmp_raw;
    assign cmp_raw = {fb_above_r1, fb_above_zh, fb_above_zl,
                      fb_below_burst_entry, short_winding_trip,
                      current_limit_trip, scaled_current_trip,
                      aux_above_overvolt, aux_below_suppress,
                      aux_valley_sense};

    logic [TMR_W-1:0] supp_len;
    logic turn_on;
    logic turn_off;
    logic cur_trip;
    logic maxoff_hit;
    logic maxon_hit;
    logic ovp_ev;
    logic sw_ev;
    logic burst_ev;
    logic [NEV-1:0] ev;
    logic [NEV-1:0] w1c;
    logic [7:0] excess;

    always_comb
    begin
        st_nxt = st_r;
        // Two-stage synchroniser
        // synchronise comparators
        st_nxt.s1 = cmp_raw;
        st_nxt.s2 = st_r.s1;
        st_nxt.val_d = st_r.s2[C_VAL];

        supp_len = st_r.long_supp ? T_LONG : T_SHORT;
        maxoff_hit = st_r.tmr >= T_MAXOFF;
        maxon_hit = st_r.tmr >= T_MAXON;
        cur_trip = (st_r.tmr >= LEADING_EDGE_BLANK_TIME)
            && (st_r.s2[C_PWM] || st_r.s2[C_ILIM]);
        turn_on = !st_r.gate && !st_r.latched && !st_r.burst
            && st_r.enable
            && ((st_r.tmr >= supp_len && st_r.valley >= st_r.load)
                || maxoff_hit);
        turn_off = st_r.gate && (maxon_hit || cur_trip || st_r.latched);

        // Gate and cycle timer
        if (turn_on || turn_off)
        begin
            st_nxt.gate = turn_on;
            st_nxt.tmr = '0;
        end
        else if (st_r.tmr != '1)
        begin
            st_nxt.tmr = st_r.tmr + TMR_W'(1);
        end
        if (turn_off)
        begin
            st_nxt.long_supp = st_r.s2[C_RS];
        end

        if (turn_on)
        begin
            st_nxt.valley = VALLEY_RST;
        end
        else if (!st_r.gate && st_r.s2[C_VAL] && !st_r.val_d
                 && st_r.valley != CNT_MAX)
        begin
            st_nxt.valley = st_r.valley + 3'h1;
        end

        st_nxt.ovp_cnt = (!st_r.gate && st_r.s2[C_OVP])
            ? inc8(st_r.ovp_cnt) : 8'h0;
        ovp_ev = st_r.ovp_cnt >= T_OVP;
        st_nxt.sw_cnt = (st_r.gate && st_r.s2[C_SW])
            ? inc8(st_r.sw_cnt) : 8'h0;
        sw_ev = st_r.sw_cnt >= T_SW;
        // Latch holds until reset
        if (ovp_ev || sw_ev)
        begin
            st_nxt.latched = 1'b1;
        end

        st_nxt.zl_seen = st_r.zl_seen || st_r.s2[C_ZL];
        st_nxt.zh_seen = st_r.zh_seen || st_r.s2[C_ZH];
        st_nxt.r1_seen = st_r.r1_seen || st_r.s2[C_R1];
        st_nxt.eval_cnt = st_r.eval_cnt + LONG_W'(1);
        if (st_r.eval_cnt >= T_EVAL - LONG_W'(1))
        begin
            st_nxt.eval_cnt = '0;
            st_nxt.zl_seen = 1'b0;
            st_nxt.zh_seen = 1'b0;
            st_nxt.r1_seen = 1'b0;
            if (st_r.r1_seen)
                st_nxt.load = LOAD_MIN;
            else if (st_r.zh_seen)
                st_nxt.load = (st_r.load > LOAD_MIN) ? st_r.load - 3'h1 : st_r.load;
            else if (!st_r.zl_seen)
                st_nxt.load = (st_r.load < CNT_MAX) ? st_r.load + 3'h1 : st_r.load;
        end

        st_nxt.beb_cnt = (st_r.s2[C_FBEB] && st_r.load == BURST_LOAD)
            ? inc_l(st_r.beb_cnt) : '0;
        burst_ev = !st_r.burst && st_r.beb_cnt >= BURST_ENTRY_BLANK_TIME;
        if (burst_ev)
        begin
            st_nxt.burst = 1'b1;
        end

        excess = (izc_code > FOLD_START) ? izc_code - FOLD_START : 8'h0;
        st_nxt.cs_limit = (excess > CS_LIMIT_MAX - CS_LIMIT_MIN)
            ? CS_LIMIT_MIN : CS_LIMIT_MAX - excess;

        // Events; a set in the clearing cycle wins
        ev = '0;
        ev[EV_OVP] = ovp_ev && !st_r.latched;
        ev[EV_SW] = sw_ev && !st_r.latched;
        ev[EV_BURST] = burst_ev;
        ev[EV_MAXOFF] = turn_on && maxoff_hit;
        ev[EV_MAXON] = turn_off && maxon_hit;
        ev[EV_ILIM] = turn_off && st_r.tmr >= LEADING_EDGE_BLANK_TIME && st_r.s2[C_ILIM];
        w1c = (reg_wr && reg_addr == A_STATUS) ? reg_wdata[NEV-1:0] : '0;
        st_nxt.status = (st_r.status & ~w1c) | ev;

        if (reg_wr && reg_addr == A_CTRL)
            st_nxt.enable = reg_wdata[0];
        if (reg_wr && reg_addr == A_MASK)
            st_nxt.mask = reg_wdata[NEV-1:0];
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);

        // Read data stands one cycle; unmapped reads zero
        st_nxt.rdata = '0;
        if (reg_rd)
        begin
            case (reg_addr)
                A_CTRL: st_nxt.rdata = {31'h0, st_r.enable};
                A_STATUS: st_nxt.rdata = {26'h0, st_r.status};
                A_MASK: st_nxt.rdata = {26'h0, st_r.mask};
                A_STATE: st_nxt.rdata = {15'h0, st_r.cs_limit, st_r.burst,
                                         st_r.latched, st_r.gate, st_r.load, st_r.valley};
                default: st_nxt.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r <= '0;
            st_r.load <= LOAD_MIN;
            st_r.cs_limit <= CS_LIMIT_MAX;
            st_r.enable <= CTRL_EN_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign gate_drive_out = st_r.gate;
    assign cs_limit = st_r.cs_limit;
    assign latched_off = st_r.latched;
    assign burst_mode = st_r.burst;
    assign irq = st_r.irq;
    assign reg_rdata = st_r.rdata;

    property p_valley_step;
        @(posedge clock) disable iff (!rstn)
        !st_r.gate && !turn_on && st_r.s2[C_VAL] && !st_r.val_d && st_r.valley < CNT_MAX
        |=> st_r.valley == $past(st_r.valley) + 3'h1;
    endproperty
    a_valley_step: assert property (p_valley_step) else $error("valley step wrong");

    property p_valley_clear;
        @(posedge clock) disable iff (!rstn)
        $rose(st_r.gate) |-> st_r.valley == VALLEY_RST;
    endproperty
    a_valley_clear: assert property (p_valley_clear) else $error("valley not cleared");

    property p_supp_hold;
        @(posedge clock) disable iff (!rstn)
        !st_r.gate && st_r.tmr < supp_len && !maxoff_hit |=> !st_r.gate;
    endproperty
    a_supp_hold: assert property (p_supp_hold) else $error("on during suppression");

    property p_maxoff;
        @(posedge clock) disable iff (!rstn)
        !st_r.gate && maxoff_hit && st_r.enable && !st_r.latched && !st_r.burst
        |=> st_r.gate && st_r.valley == VALLEY_RST;
    endproperty
    a_maxoff: assert property (p_maxoff) else $error("max off ignored");

    property p_leb;
        @(posedge clock) disable iff (!rstn)
        st_r.gate && st_r.tmr < LEADING_EDGE_BLANK_TIME && !st_r.latched |=> st_r.gate;
    endproperty
    a_leb: assert property (p_leb) else $error("off inside blanking");

    property p_maxon;
        @(posedge clock) disable iff (!rstn)
        st_r.gate && st_r.tmr >= T_MAXON |=> !st_r.gate;
    endproperty
    a_maxon: assert property (p_maxon) else $error("max on ignored");

    property p_ilim;
        @(posedge clock) disable iff (!rstn)
        st_r.gate && st_r.tmr >= LEADING_EDGE_BLANK_TIME && st_r.s2[C_ILIM] |=> !st_r.gate ##1 !st_r.gate;
    endproperty
    a_ilim: assert property (p_ilim) else $error("limit trip ignored");

    property p_load_range;
        @(posedge clock) disable iff (!rstn)
        $changed(st_r.load) |-> st_r.load >= LOAD_MIN && $past(st_r.eval_cnt) == T_EVAL - LONG_W'(1);
    endproperty
    a_load_range: assert property (p_load_range) else $error("load counter off period");

    property p_burst;
        @(posedge clock) disable iff (!rstn)
        $rose(st_r.burst) |-> $past(st_r.load) == BURST_LOAD && $past(st_r.s2[C_FBEB]);
    endproperty
    a_burst: assert property (p_burst) else $error("burst entered wrongly");
endmodule : qrst_core
`default_nettype wire

//--- hdl/qrst_pkg.sv
// Constants shared by the quasi-resonant switch timing core.
// Assumes a single 10 MHz clock; times are turned into cycle counts here.
package qrst_pkg;
    // Clock and documented times
    localparam int CLK_NS = 100;
    localparam int MAX_OFF_NS = 50000;
    localparam int EVAL_MS = 48;
    localparam int BURST_BLANK_MS = 24;
    localparam int MAX_OFF_CYC = MAX_OFF_NS / CLK_NS;
    localparam int EVAL_CYC = EVAL_MS * 1000000 / CLK_NS;
    localparam int BURST_BLANK_CYC = BURST_BLANK_MS * 1000000 / CLK_NS;
    // Durations given only as cycle counts
    localparam int SHORT_SUPP_CYC = 20;
    localparam int LONG_SUPP_CYC = 60;
    localparam int LEB_CYC = 3;
    localparam int MAX_ON_CYC = 250;
    localparam int OVP_BLANK_CYC = 10;
    localparam int SW_BLANK_CYC = 2;
    localparam int TMR_W = 16;
    localparam int LONG_W = 20;
    // Counter limits and reset values
    localparam logic [2:0] VALLEY_RST = 3'h0;
    localparam logic [2:0] CNT_MAX = 3'h7;
    localparam logic [2:0] LOAD_MIN = 3'h1;
    localparam logic [2:0] BURST_LOAD = 3'h7;
    // Foldback of the current sense limit
    localparam logic [7:0] CS_LIMIT_MAX = 8'hff;
    localparam logic [7:0] CS_LIMIT_MIN = 8'h40;
    localparam logic [7:0] FOLD_START = 8'h40;
    // Synchroniser lanes
    localparam int C_VAL = 0;
    localparam int C_RS = 1;
    localparam int C_OVP = 2;
    localparam int C_PWM = 3;
    localparam int C_ILIM = 4;
    localparam int C_SW = 5;
    localparam int C_FBEB = 6;
    localparam int C_ZL = 7;
    localparam int C_ZH = 8;
    localparam int C_R1 = 9;
    localparam int NCMP = 10;
    // Register map, byte addresses
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_STATUS = 4'h4;
    localparam logic [3:0] A_MASK = 4'h8;
    localparam logic [3:0] A_STATE = 4'hc;
    // Status and mask bits
    localparam int EV_OVP = 0;
    localparam int EV_SW = 1;
    localparam int EV_BURST = 2;
    localparam int EV_MAXOFF = 3;
    localparam int EV_MAXON = 4;
    localparam int EV_ILIM = 5;
    localparam int NEV = 6;
    localparam logic CTRL_EN_RST = 1'b1;
endpackage : qrst_pkg

//--- verif/qrst_partner.sv
// Far side model: power switch sense current and aux winding ringing.
// Assumes the gate drive is a registered level on the same clock.
`timescale 1ns/10ps
`default_nettype none
module qrst_partner
(
    // Clock and gate
    input wire logic clock,
    input wire logic gate_drive_out,
    // Scenario knobs: trip delay (0 at once, ff never), ringing, suppress level
    input wire logic [7:0] trip_after,
    input wire logic use_scaled,
    input wire logic ring_on,
    input wire logic supp_low,
    // Comparator levels
    output logic scaled_current_trip,
    output logic current_limit_trip,
    output logic aux_valley_sense,
    output logic aux_below_suppress
);
    logic [7:0] cnt_r = 8'h00;
    logic gate_q = 1'b0;
    logic trip;
    always @(posedge clock)
    begin
        gate_q <= gate_drive_out;
        cnt_r <= (gate_q != gate_drive_out) ? 8'h00 : cnt_r + 8'h01;
    end
    // Sense rises with on-time; nothing while the switch is off
    assign trip = gate_drive_out && (trip_after == 8'h00 || (gate_q && cnt_r >= trip_after));
    assign scaled_current_trip = trip && use_scaled;
    assign current_limit_trip = trip && !use_scaled;
    // One falling crossing every 8 cycles while off
    assign aux_valley_sense = !gate_drive_out && ring_on && cnt_r[2];
    assign aux_below_suppress = supp_low;
endmodule : qrst_partner
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the switching control core.
// Assumes the core and the far side model share one 10 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import qrst_pkg::*;
    localparam int EVAL = 64;
    localparam int BBLANK = 32;
    logic clock = 1'b0, rstn = 1'b0, aux_above_overvolt = 1'b0, short_winding_trip = 1'b0;
    logic fb_below_burst_entry = 1'b0, fb_above_zl = 1'b0, fb_above_zh = 1'b0, fb_above_r1 = 1'b1;
    logic [7:0] izc_code = 8'h00, trip_after = 8'hff;
    logic use_scaled = 1'b0, ring_on = 1'b0, supp_low = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d, e;
    logic aux_valley_sense, aux_below_suppress, scaled_current_trip, current_limit_trip;
    logic gate_drive_out, latched_off, burst_mode, irq, g_q = 1'b0;
    logic [7:0] cs_limit;
    int num_errors = 0, num_checks = 0, cyc = 0, run = 0, lo_w = 0, hi_w = 0, seed = 99, i;
    logic [7:0] v;
    always #50 clock = ~clock;
    qrst_core #(.EVAL_CYCLES(EVAL), .BURST_BLANK_CYCLES(BBLANK)) i_qrst_core (.clock(clock), .rstn(rstn),
        .aux_valley_sense(aux_valley_sense), .aux_below_suppress(aux_below_suppress),
        .aux_above_overvolt(aux_above_overvolt), .scaled_current_trip(scaled_current_trip),
        .current_limit_trip(current_limit_trip), .short_winding_trip(short_winding_trip),
        .fb_below_burst_entry(fb_below_burst_entry), .fb_above_zl(fb_above_zl), .fb_above_zh(fb_above_zh),
        .fb_above_r1(fb_above_r1), .izc_code(izc_code), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gate_drive_out(gate_drive_out),
        .cs_limit(cs_limit), .latched_off(latched_off), .burst_mode(burst_mode), .irq(irq));
    qrst_partner i_qrst_partner (.clock(clock), .gate_drive_out(gate_drive_out), .trip_after(trip_after),
        .use_scaled(use_scaled), .ring_on(ring_on), .supp_low(supp_low),
        .scaled_current_trip(scaled_current_trip), .current_limit_trip(current_limit_trip),
        .aux_valley_sense(aux_valley_sense), .aux_below_suppress(aux_below_suppress));
    // Width in cycles of the last high and low gate phase
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (gate_drive_out !== g_q)
        begin
            if (g_q === 1'b1)
                hi_w <= run;
            else
                lo_w <= run;
            run <= 1;
            g_q <= gate_drive_out;
        end
        else
            run <= run + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_in(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi)
        begin
            num_errors++;
            $display("[ERR] %0t got %h range %h to %h", $time, got, lo, hi);
        end
    endtask : chk_in
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [31:0] w);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] q);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        // Sampled mid-cycle, clear of the edge that ends it
        @(negedge clock);
        q = reg_rdata;
    endtask : rd
    task automatic edge_to(input logic lvl);
        for (i = 0; i < 1200 && gate_drive_out === lvl; i++) @(posedge clock);
        for (i = 0; i < 1200 && gate_drive_out !== lvl; i++) @(posedge clock);
        @(posedge clock);
    endtask : edge_to
    task automatic do_reset();
        rstn <= 1'b0;
        tick(5);
        rstn <= 1'b1;
        tick(1);
    endtask : do_reset
    function automatic logic [7:0] fold(input logic [7:0] x);
        if (x <= FOLD_START)
            return CS_LIMIT_MAX;
        if (9'(CS_LIMIT_MAX) - 9'(x - FOLD_START) < 9'(CS_LIMIT_MIN))
            return CS_LIMIT_MIN;
        return CS_LIMIT_MAX - (x - FOLD_START);
    endfunction : fold
    initial
    begin
        do_reset();
        chk({gate_drive_out, latched_off, burst_mode, irq, cs_limit}, {4'h0, CS_LIMIT_MAX});
        rd(A_STATE, d);
        chk(d, {15'h0, CS_LIMIT_MAX, 3'h0, LOAD_MIN, VALLEY_RST});
        rd(A_CTRL, d);
        chk(d, 32'h1);
        rd(4'h2, d);
        chk(d, 32'h0);
        $display("test reset done");
        edge_to(1'b1);
        edge_to(1'b0);
        chk_in(hi_w, MAX_ON_CYC, MAX_ON_CYC + 4);
        edge_to(1'b1);
        chk_in(lo_w, MAX_OFF_CYC, MAX_OFF_CYC + 4);
        wr(A_MASK, 32'h8);
        wr(A_CTRL, 32'h0);
        rd(A_STATUS, d);
        chk(d, 32'h18);
        chk(irq, 1'b1);
        edge_to(1'b0);
        wr(A_STATUS, 32'h8);
        rd(A_STATUS, d);
        chk({d[30:0], irq}, {31'h10, 1'b0});
        tick(600);
        chk(gate_drive_out, 1'b0);
        wr(A_CTRL, 32'h1);
        $display("test timeouts done");
        ring_on <= 1'b1;
        edge_to(1'b1);
        edge_to(1'b1);
        chk_in(lo_w, SHORT_SUPP_CYC, SHORT_SUPP_CYC + 4);
        rd(A_STATE, d);
        chk(d & 32'h47, 32'h40);
        supp_low <= 1'b1;
        edge_to(1'b1);
        edge_to(1'b1);
        chk_in(lo_w, LONG_SUPP_CYC, LONG_SUPP_CYC + 4);
        trip_after <= 8'h00;
        edge_to(1'b0);
        edge_to(1'b0);
        chk_in(hi_w, LEB_CYC + 1, LEB_CYC + 4);
        rd(A_STATUS, d);
        chk(d[EV_ILIM], 1'b1);
        use_scaled <= 1'b1;
        trip_after <= 8'd40;
        edge_to(1'b0);
        edge_to(1'b0);
        chk_in(hi_w, 40, 46);
        $display("test switching done");
        {use_scaled, trip_after, supp_low, fb_above_r1} <= {1'b0, 8'h00, 1'b0, 1'b0};
        tick(8 * EVAL);
        rd(A_STATE, d);
        chk(d[5:3], CNT_MAX);
        edge_to(1'b1);
        edge_to(1'b1);
        chk_in(lo_w, 52, 62);
        {fb_above_zl, fb_above_zh} <= 2'h3;
        tick(2 * EVAL + 8);
        rd(A_STATE, d);
        chk_in(d[5:3], 4, 6);
        fb_above_zh <= 1'b0;
        tick(EVAL + 8);
        rd(A_STATE, d);
        tick(2 * EVAL);
        rd(A_STATE, e);
        chk(e[5:3], d[5:3]);
        fb_above_zl <= 1'b0;
        fb_above_r1 <= 1'b1;
        tick(2 * EVAL + 8);
        rd(A_STATE, d);
        chk(d[5:3], LOAD_MIN);
        fb_below_burst_entry <= 1'b1;
        tick(BBLANK + 16);
        chk(burst_mode, 1'b0);
        fb_above_r1 <= 1'b0;
        tick(8 * EVAL + BBLANK);
        rd(A_STATUS, d);
        chk({burst_mode, d[EV_BURST]}, 2'h3);
        $display("test load and burst done");
        fb_below_burst_entry <= 1'b0;
        do_reset();
        for (int k = 0; k < 24; k++)
        begin
            v = (k < 4) ? ((k < 2) ? {1'b0, k[0], 6'h0} : {7'h7f, k[0]}) : 8'($random(seed));
            izc_code <= v;
            tick(4);
            chk(cs_limit, fold(v));
        end
        $display("test foldback done");
        {trip_after, ring_on} <= {8'hff, 1'b0};
        edge_to(1'b1);
        short_winding_trip <= 1'b1;
        tick(1);
        short_winding_trip <= 1'b0;
        tick(8);
        chk(latched_off, 1'b0);
        short_winding_trip <= 1'b1;
        tick(8);
        short_winding_trip <= 1'b0;
        rd(A_STATUS, d);
        chk({latched_off, gate_drive_out, d[EV_SW]}, 3'h5);
        do_reset();
        aux_above_overvolt <= 1'b1;
        tick(OVP_BLANK_CYC - 5);
        aux_above_overvolt <= 1'b0;
        tick(8);
        chk(latched_off, 1'b0);
        aux_above_overvolt <= 1'b1;
        tick(OVP_BLANK_CYC + 8);
        chk(latched_off, 1'b1);
        rd(A_STATUS, d);
        chk(d[EV_OVP], 1'b1);
        $display("test latch off done");
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
